// file: include/abe_pkg.sv
// Constants, field layout and types of the add, logic and branch execute block.
// Assumes a 32-bit instruction word whose bit 31 is the most significant bit.
package abe_pkg;

	// ----------------------------------------------------------------
	// Datapath widths
	// ----------------------------------------------------------------
	localparam int XLEN = 32;
	localparam int REG_AW = 5;
	localparam int IMM_W = 16;
	localparam int OPC_W = 6;

	// ----------------------------------------------------------------
	// Instruction fields, as vector positions of instrWord[31:0]
	// ----------------------------------------------------------------
	localparam int OPC_LSB = 26;
	localparam int RD_LSB = 21;
	localparam int SRCA_LSB = 16;
	localparam int SRCB_LSB = 11;
	localparam int TAIL_W = 11;
	localparam int TYPEB_BIT = 29;
	localparam int KEEP_BIT = 28;
	localparam int CARRY_BIT = 27;
	localparam int DELAY_BIT = 25;
	localparam int COND_LSB = 21;
	localparam int COND_W = 4;

	// ----------------------------------------------------------------
	// Opcodes
	// ----------------------------------------------------------------
	localparam logic [OPC_W-1:0] ADD_MASK = 6'h39;
	localparam logic [OPC_W-1:0] OPC_ADD = 6'h00;
	localparam logic [OPC_W-1:0] OPC_ADDI = 6'h08;
	localparam logic [OPC_W-1:0] OPC_AND = 6'h21;
	localparam logic [OPC_W-1:0] OPC_ANDI = 6'h29;
	localparam logic [OPC_W-1:0] OPC_ANDN = 6'h23;
	localparam logic [OPC_W-1:0] OPC_ANDNI = 6'h2b;
	localparam logic [OPC_W-1:0] OPC_BEQ = 6'h27;
	localparam logic [OPC_W-1:0] OPC_BEQI = 6'h2f;
	localparam logic [COND_W-1:0] COND_EQ = 4'h0;

	// ----------------------------------------------------------------
	// Register map, byte addresses on APB
	// ----------------------------------------------------------------
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_PC = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_RETIRED = 8'h0c;
	localparam int CTRL_RUN_BIT = 0;
	localparam int STAT_CARRY_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_ILLEGAL_BIT = 2;
	localparam logic CTRL_RUN_RESET = 1'b0;
	localparam logic [XLEN-1:0] PC_RESET = 32'h0000_0000;
	localparam logic [XLEN-1:0] PC_STEP = 32'h0000_0004;

	// ----------------------------------------------------------------
	// Branch latencies in cycles, kept by the sequencer states
	// ----------------------------------------------------------------
	localparam int LAT_NOT_TAKEN = 1;
	localparam int LAT_TAKEN_DELAY = 2;
	localparam int LAT_TAKEN_NODELAY = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ALU_ADD = 2'b00,
		ALU_AND = 2'b01,
		ALU_ANDN = 2'b10
	} abe_aluop_type;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b00,
		ST_STALL2 = 2'b01,
		ST_STALL1 = 2'b11,
		ST_SLOT = 2'b10
	} abe_state_type;

endpackage : abe_pkg

// file: include/abe_alu_if.sv
// Operand and result bundle between the sequencer and the arithmetic unit.
// Assumes both ends sit on the same clock; the bundle itself is combinational.
`timescale 1ns/1ps
interface abe_alu_if;
	abe_pkg::abe_aluop_type op;
	logic [abe_pkg::XLEN-1:0] opA;
	logic [abe_pkg::XLEN-1:0] opB;
	logic carryIn;
	logic [abe_pkg::XLEN-1:0] result;
	logic carryOut;

	modport exec (output op, output opA, output opB, output carryIn,
		input result, input carryOut);
	modport alu (input op, input opA, input opB, input carryIn,
		output result, output carryOut);
endinterface : abe_alu_if

// file: verilog/abe_alu.sv
// Single-cycle adder and logic unit of the execute block.
// Assumes the caller has already chosen operands and the carry-in.
`timescale 1ns/1ps
module abe_alu (
	// Operands and results
	abe_alu_if.alu bus
);

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	logic [abe_pkg::XLEN:0] sum;

	// The carry-in is already gated by the instruction's carry select.
	assign sum = (abe_pkg::XLEN+1)'(bus.opA) + (abe_pkg::XLEN+1)'(bus.opB)
		+ (abe_pkg::XLEN+1)'(bus.carryIn);

	always_comb begin
		case (bus.op)
			abe_pkg::ALU_ADD: begin
				bus.result = sum[abe_pkg::XLEN-1:0];
			end
			abe_pkg::ALU_AND: begin
				bus.result = bus.opA & bus.opB;
			end
			abe_pkg::ALU_ANDN: begin
				bus.result = bus.opA & ~bus.opB;
			end
			default: begin
				bus.result = '0;
			end
		endcase
	end

	assign bus.carryOut = sum[abe_pkg::XLEN];

endmodule : abe_alu

// file: verilog/abe_exec_top.sv
// Decode and execute unit for add, AND, AND-NOT and branch-if-zero instructions.
// Assumes a fetch unit that offers one instruction with valid/ready, a register
// file with combinational read ports, and an imm-prefix flag from the core.
`timescale 1ns/1ps
module abe_exec_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB register slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [abe_pkg::APB_AW-1:0] paddr,
	input wire logic [abe_pkg::XLEN-1:0] pwdata,
	output logic [abe_pkg::XLEN-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Instruction issue
	input wire logic instrValid,
	input wire logic [abe_pkg::XLEN-1:0] instrWord,
	output logic instrReady,
	// Immediate prefix from the preceding instruction
	input wire logic immPrefixValid,
	input wire logic [abe_pkg::IMM_W-1:0] immPrefixHigh,
	// Register file read ports
	output logic [abe_pkg::REG_AW-1:0] rdAddrA,
	output logic [abe_pkg::REG_AW-1:0] rdAddrB,
	input wire logic [abe_pkg::XLEN-1:0] rdDataA,
	input wire logic [abe_pkg::XLEN-1:0] rdDataB,
	// Register file write port
	output logic wrEn,
	output logic [abe_pkg::REG_AW-1:0] wrAddr,
	output logic [abe_pkg::XLEN-1:0] wrData,
	// Program counter and fetch redirect
	output logic [abe_pkg::XLEN-1:0] pcOut,
	output logic redirectValid,
	output logic [abe_pkg::XLEN-1:0] redirectPc,
	// Status carry flag
	output logic statusCarryFlag
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	abe_pkg::abe_state_type state_ff;
	abe_pkg::abe_state_type nxt_state;
	logic [abe_pkg::XLEN-1:0] pc_ff;
	logic [abe_pkg::XLEN-1:0] target_ff;
	logic carry_ff;
	logic wrEn_ff;
	logic [abe_pkg::REG_AW-1:0] wrAddr_ff;
	logic [abe_pkg::XLEN-1:0] wrData_ff;
	logic redirect_ff;
	logic [abe_pkg::XLEN-1:0] redirectPc_ff;
	logic run_ff;
	logic illegal_ff;
	logic [abe_pkg::XLEN-1:0] retired_ff;
	logic [abe_pkg::XLEN-1:0] prdata_ff;
	logic pslverr_ff;

	abe_alu_if aluBus ();

	abe_alu u_alu (
		.bus(aluBus)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic [abe_pkg::OPC_W-1:0] opcode;
	logic [abe_pkg::REG_AW-1:0] fieldD;
	logic [abe_pkg::IMM_W-1:0] imm16;
	logic isTypeB;
	logic keepCarry;
	logic useCarry;
	logic delayBit;
	logic tailZero;
	logic isAdd;
	logic isAnd;
	logic isAndn;
	logic isBeq;
	logic legal;

	assign opcode = instrWord[abe_pkg::OPC_LSB +: abe_pkg::OPC_W];
	assign fieldD = instrWord[abe_pkg::RD_LSB +: abe_pkg::REG_AW];
	assign rdAddrA = instrWord[abe_pkg::SRCA_LSB +: abe_pkg::REG_AW];
	assign rdAddrB = instrWord[abe_pkg::SRCB_LSB +: abe_pkg::REG_AW];
	assign imm16 = instrWord[abe_pkg::IMM_W-1:0];
	assign isTypeB = instrWord[abe_pkg::TYPEB_BIT];
	assign keepCarry = instrWord[abe_pkg::KEEP_BIT];
	assign useCarry = instrWord[abe_pkg::CARRY_BIT];
	assign delayBit = instrWord[abe_pkg::DELAY_BIT];
	// Register forms with stray bits in the zero tail are refused as illegal.
	assign tailZero = isTypeB || (instrWord[abe_pkg::TAIL_W-1:0] == '0);

	assign isAdd = ((opcode & abe_pkg::ADD_MASK) == abe_pkg::OPC_ADD)
		|| ((opcode & abe_pkg::ADD_MASK) == abe_pkg::OPC_ADDI);
	assign isAnd = (opcode == abe_pkg::OPC_AND) || (opcode == abe_pkg::OPC_ANDI);
	assign isAndn = (opcode == abe_pkg::OPC_ANDN) || (opcode == abe_pkg::OPC_ANDNI);
	// The destination field of a branch carries the delay bit and the condition.
	assign isBeq = ((opcode == abe_pkg::OPC_BEQ) || (opcode == abe_pkg::OPC_BEQI))
		&& (instrWord[abe_pkg::COND_LSB +: abe_pkg::COND_W] == abe_pkg::COND_EQ);
	assign legal = (isAdd || isAnd || isAndn || isBeq) && tailZero;

	// ----------------------------------------------------------------
	// Operands
	// ----------------------------------------------------------------
	logic [abe_pkg::XLEN-1:0] immExt;
	logic [abe_pkg::XLEN-1:0] srcA;
	logic [abe_pkg::XLEN-1:0] srcB;
	logic [abe_pkg::XLEN-1:0] operandB;

	always_comb begin
		if (immPrefixValid) begin
			immExt = {immPrefixHigh, imm16};
		end else begin
			immExt = {{(abe_pkg::XLEN-abe_pkg::IMM_W){imm16[abe_pkg::IMM_W-1]}}, imm16};
		end
	end

	// The write port lands one edge late, so results are forwarded to the next
	// instruction instead of stalling it.
	assign srcA = (wrEn_ff && (wrAddr_ff == rdAddrA)) ? wrData_ff : rdDataA;
	assign srcB = (wrEn_ff && (wrAddr_ff == rdAddrB)) ? wrData_ff : rdDataB;
	assign operandB = isTypeB ? immExt : srcB;

	always_comb begin
		if (isAnd) begin
			aluBus.op = abe_pkg::ALU_AND;
		end else if (isAndn) begin
			aluBus.op = abe_pkg::ALU_ANDN;
		end else begin
			aluBus.op = abe_pkg::ALU_ADD;
		end
	end

	assign aluBus.opA = srcA;
	assign aluBus.opB = operandB;
	// The select bit only chooses whether the stored flag joins the sum.
	assign aluBus.carryIn = useCarry & carry_ff;

	// ----------------------------------------------------------------
	// Issue and branch decision
	// ----------------------------------------------------------------
	logic accept;
	logic execute;
	logic branchTaken;
	logic [abe_pkg::XLEN-1:0] branchTarget;

	assign instrReady = run_ff && ((state_ff == abe_pkg::ST_EXEC) || (state_ff == abe_pkg::ST_SLOT));
	assign accept = instrValid && instrReady;
	// A branch sitting in a delay slot is refused; it would need a second target.
	assign execute = accept && legal && !(isBeq && (state_ff == abe_pkg::ST_SLOT));
	assign branchTaken = execute && isBeq && (srcA == '0);
	assign branchTarget = pc_ff + operandB;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			abe_pkg::ST_EXEC: begin
				if (branchTaken && delayBit) begin
					nxt_state = abe_pkg::ST_STALL1;
				end else if (branchTaken) begin
					nxt_state = abe_pkg::ST_STALL2;
				end
			end
			abe_pkg::ST_STALL2: begin
				nxt_state = abe_pkg::ST_STALL1;
			end
			abe_pkg::ST_STALL1: begin
				nxt_state = (target_ff == pc_ff) ? abe_pkg::ST_EXEC : abe_pkg::ST_SLOT;
			end
			abe_pkg::ST_SLOT: begin
				if (accept) begin
					nxt_state = abe_pkg::ST_EXEC;
				end
			end
			default: begin
				nxt_state = abe_pkg::ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= abe_pkg::ST_EXEC;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Program counter and redirect
	// ----------------------------------------------------------------
	// Without delay the counter takes the target at once, which also tells the
	// stall state that no slot follows; with delay the slot runs at pc + 4.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_ff <= abe_pkg::PC_RESET;
			target_ff <= abe_pkg::PC_RESET;
		end else if (branchTaken && !delayBit) begin
			pc_ff <= branchTarget;
			target_ff <= branchTarget;
		end else if (branchTaken) begin
			pc_ff <= pc_ff + abe_pkg::PC_STEP;
			target_ff <= branchTarget;
		end else if (accept && (state_ff == abe_pkg::ST_SLOT)) begin
			pc_ff <= target_ff;
		end else if (accept) begin
			pc_ff <= pc_ff + abe_pkg::PC_STEP;
		end else if (psel && penable && pwrite && !run_ff && (paddr == abe_pkg::ADDR_PC)) begin
			pc_ff <= pwdata;
			target_ff <= pwdata;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			redirect_ff <= 1'b0;
			redirectPc_ff <= abe_pkg::PC_RESET;
		end else if (branchTaken && !delayBit) begin
			redirect_ff <= 1'b1;
			redirectPc_ff <= branchTarget;
		end else if (accept && (state_ff == abe_pkg::ST_SLOT)) begin
			redirect_ff <= 1'b1;
			redirectPc_ff <= target_ff;
		end else begin
			redirect_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Carry flag
	// ----------------------------------------------------------------
	// An executing add without the keep bit wins over a software write landing in the same cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carry_ff <= 1'b0;
		end else if (execute && isAdd && !keepCarry) begin
			carry_ff <= aluBus.carryOut;
		end else if (psel && penable && pwrite && (paddr == abe_pkg::ADDR_STATUS)) begin
			carry_ff <= pwdata[abe_pkg::STAT_CARRY_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Register file write port
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrEn_ff <= 1'b0;
			wrAddr_ff <= '0;
			wrData_ff <= '0;
		end else begin
			wrEn_ff <= execute && !isBeq;
			if (execute && !isBeq) begin
				wrAddr_ff <= fieldD;
				wrData_ff <= aluBus.result;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control and status registers
	// ----------------------------------------------------------------
	logic apbWrite;
	logic apbSetup;
	logic mapped;

	assign apbWrite = psel && penable && pwrite;
	assign apbSetup = psel && !penable;
	assign mapped = (paddr == abe_pkg::ADDR_CTRL) || (paddr == abe_pkg::ADDR_STATUS)
		|| (paddr == abe_pkg::ADDR_PC) || (paddr == abe_pkg::ADDR_RETIRED);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_ff <= abe_pkg::CTRL_RUN_RESET;
		end else if (apbWrite && (paddr == abe_pkg::ADDR_CTRL)) begin
			run_ff <= pwdata[abe_pkg::CTRL_RUN_BIT];
		end
	end

	// Sticky; a refusal in the same cycle as a write-one-to-clear stays set.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			illegal_ff <= 1'b0;
		end else if (accept && !execute) begin
			illegal_ff <= 1'b1;
		end else if (apbWrite && (paddr == abe_pkg::ADDR_STATUS)
			&& pwdata[abe_pkg::STAT_ILLEGAL_BIT]) begin
			illegal_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			retired_ff <= '0;
		end else if (execute) begin
			retired_ff <= retired_ff + 32'h0000_0001;
		end else if (apbWrite && (paddr == abe_pkg::ADDR_RETIRED)) begin
			retired_ff <= '0;
		end
	end

	// Read data is captured in the setup cycle so the zero-wait access phase
	// returns it straight from a flip-flop.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end else if (apbSetup) begin
			pslverr_ff <= !mapped;
			case (paddr)
				abe_pkg::ADDR_CTRL: begin
					prdata_ff <= 32'(run_ff);
				end
				abe_pkg::ADDR_STATUS: begin
					prdata_ff <= '0;
					prdata_ff[abe_pkg::STAT_CARRY_BIT] <= carry_ff;
					prdata_ff[abe_pkg::STAT_BUSY_BIT] <= (state_ff != abe_pkg::ST_EXEC);
					prdata_ff[abe_pkg::STAT_ILLEGAL_BIT] <= illegal_ff;
				end
				abe_pkg::ADDR_PC: begin
					prdata_ff <= pc_ff;
				end
				abe_pkg::ADDR_RETIRED: begin
					prdata_ff <= retired_ff;
				end
				default: begin
					prdata_ff <= '0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = pslverr_ff && psel && penable;
	assign wrEn = wrEn_ff;
	assign wrAddr = wrAddr_ff;
	assign wrData = wrData_ff;
	assign pcOut = pc_ff;
	assign redirectValid = redirect_ff;
	assign redirectPc = redirectPc_ff;
	assign statusCarryFlag = carry_ff;

endmodule : abe_exec_top

// file: testbench/abe_exec_props.sv
// Concurrent checks on the ports of the execute block's top module.
// Assumes one clock and the active-high asynchronous reset of the top module.
`timescale 1ns/1ps
module abe_exec_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Issue and register file
	input wire logic instrValid,
	input wire logic instrReady,
	input wire logic [31:0] instrWord,
	input wire logic immPrefixValid,
	input wire logic [15:0] immPrefixHigh,
	input wire logic [4:0] rdAddrA,
	input wire logic [4:0] rdAddrB,
	input wire logic [31:0] rdDataA,
	input wire logic [31:0] rdDataB,
	// Results
	input wire logic wrEn,
	input wire logic [4:0] wrAddr,
	input wire logic [31:0] wrData,
	input wire logic [31:0] pcOut,
	input wire logic redirectValid,
	input wire logic [31:0] redirectPc,
	input wire logic statusCarryFlag
);
	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Operands that the design forwards are not seen at the ports, so those cycles are skipped.
	wire logic acc = instrValid && instrReady;
	wire logic [5:0] opc = instrWord[31:26];
	wire logic clean = !(wrEn && (wrAddr == rdAddrA || wrAddr == rdAddrB));
	wire logic addFam = opc[5:4] == 2'b00 && !opc[0];
	wire logic isBr = acc && clean && instrWord[24:21] == 4'h0 &&
		(opc == abe_pkg::OPC_BEQ || opc == abe_pkg::OPC_BEQI);
	wire logic isAlu = acc && clean && (opc[3] || instrWord[10:0] == 11'h0) && (addFam ||
		opc == abe_pkg::OPC_AND || opc == abe_pkg::OPC_ANDN || opc == abe_pkg::OPC_ANDI);
	wire logic [31:0] offB = opc[3] ?
		{immPrefixValid ? immPrefixHigh : {16{instrWord[15]}}, instrWord[15:0]} : rdDataB;
	wire logic [32:0] sumAB = {1'b0, rdDataA} + {1'b0, rdDataB};
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence stallTwo;
		!instrReady [*2] ##1 instrReady;
	endsequence
	sequence stallOne;
		!instrReady ##1 instrReady;
	endsequence
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	br_nodelay_a: assert property (isBr && rdDataA == 0 && !instrWord[25]
		|=> stallTwo)
		else $error("taken branch without slot did not stall two cycles");
	br_delay_a: assert property (isBr && rdDataA == 0 && instrWord[25]
		&& offB != 32'h4 |=> stallOne)
		else $error("taken branch with slot did not stall one cycle");
	br_target_a: assert property (isBr && rdDataA == 0 && !instrWord[25] |=>
		redirectValid && redirectPc == $past(pcOut) + $past(offB))
		else $error("branch target is not pc plus offset");
	br_skip_a: assert property (isBr && rdDataA != 0 |=>
		instrReady && !redirectValid && pcOut == $past(pcOut) + 32'h4)
		else $error("branch not taken did not step by four");
	// A target that is itself a taken branch may redirect again at once, so only
	// a redirect cycle without a new instruction must be followed by silence.
	redir_once_a: assert property (redirectValid && !acc |=> !redirectValid)
		else $error("redirect repeated without a new instruction");
	and_res_a: assert property (isAlu && opc == abe_pkg::OPC_AND |=>
		wrEn && wrData == $past(rdDataA & rdDataB))
		else $error("and result wrong");
	andn_res_a: assert property (isAlu && opc == abe_pkg::OPC_ANDN |=>
		wrEn && wrData == $past(rdDataA & ~rdDataB))
		else $error("and-not result wrong");
	add_res_a: assert property (isAlu && opc == abe_pkg::OPC_ADD |=>
		wrData == $past(sumAB[31:0]) && statusCarryFlag == $past(sumAB[32]))
		else $error("plain add result or carry wrong");
	keep_carry_a: assert property (acc && addFam && opc[2] |=>
		$stable(statusCarryFlag))
		else $error("keep-carry add changed the carry flag");
	wr_addr_a: assert property (isAlu |=>
		wrEn && wrAddr == $past(instrWord[25:21]))
		else $error("result written to wrong register");
endmodule : abe_exec_props

// file: testbench/tb_abe_exec_top.sv
// Self-checking bench for the execute block: APB set-up, then instruction streams.
// Assumes the bench plays fetch and a combinational register file written on wrEn.
`timescale 1ns/1ps
module tb_abe_exec_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdDataA, rdDataB, wrData, pcOut, redirectPc;
	logic pready, pslverr, instrReady, wrEn, redirectValid, statusCarryFlag;
	logic instrValid = 1'b0, immPrefixValid = 1'b0;
	logic [31:0] instrWord = 32'h0;
	logic [15:0] immPrefixHigh = 16'h0;
	logic [4:0] rdAddrA, rdAddrB, wrAddr;
	logic [31:0] rf [32];
	logic [31:0] mrf [32];
	logic [31:0] mpc = 32'h0, slotTgt = 32'h0;
	logic mc = 1'b0, slotPend = 1'b0;
	logic [37:0] wq [$];
	logic [31:0] rq [$];
	int expGap = 0, cyc = 0, lastAcc = 0, fails = 0, n_checks = 0;
	assign rdDataA = rf[rdAddrA];
	assign rdDataB = rf[rdAddrB];
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	abe_exec_top abe_exec_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instrValid(instrValid), .instrWord(instrWord),
		.instrReady(instrReady), .immPrefixValid(immPrefixValid), .immPrefixHigh(immPrefixHigh),
		.rdAddrA(rdAddrA), .rdAddrB(rdAddrB), .rdDataA(rdDataA), .rdDataB(rdDataB),
		.wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .pcOut(pcOut),
		.redirectValid(redirectValid), .redirectPc(redirectPc), .statusCarryFlag(statusCarryFlag));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		n_checks++;
		if (seen !== want) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin fails++; report_and_stop(); end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] d,
		input logic [4:0] a, input logic [15:0] lo);
		return {op, d, a, lo};
	endfunction : mk
	// Expected effect of one accepted instruction on the bench's copy of the core state.
	task automatic model(input logic [31:0] iw, input logic pv, input logic [15:0] ph);
		logic [5:0] op;
		logic [31:0] a, b, tgt;
		logic [32:0] s;
		op = iw[31:26];
		a = mrf[iw[20:16]];
		b = op[3] ? {pv ? ph : {16{iw[15]}}, iw[15:0]} : mrf[iw[15:11]];
		if (op[2:0] == 3'b111) begin
			tgt = mpc + b;
			expGap = (a != 0) ? 1 : (iw[25] ? 2 : 3);
			if (a == 32'h0) rq.push_back(tgt);
			slotPend = a == 32'h0 && iw[25];
			slotTgt = tgt;
			mpc = (a == 32'h0 && !iw[25]) ? tgt : mpc + 32'h4;
		end else begin
			s = {1'b0, a} + {1'b0, b} + {32'h0, op[1] & mc};
			if (op[5]) s[31:0] = op[1] ? (a & ~b) : (a & b);
			else if (!op[2]) mc = s[32];
			mrf[iw[25:21]] = s[31:0];
			wq.push_back({iw[25:21], s[31:0], mc});
			expGap = slotPend ? 0 : 1;
			mpc = slotPend ? slotTgt : mpc + 32'h4;
			slotPend = 1'b0;
		end
	endtask : model
	task automatic issue(input logic [31:0] iw, input logic pv = 1'b0, input logic [15:0] ph = 16'h0);
		int n;
		instrValid <= 1'b1;
		instrWord <= iw;
		immPrefixValid <= pv;
		immPrefixHigh <= ph;
		n = 0;
		do begin @(posedge clk); n++; end while (instrReady !== 1'b1 && n < 50);
		if (n >= 50) begin fails++; report_and_stop(); end
		if (expGap > 0) check(cyc - lastAcc, expGap);
		check(pcOut, mpc);
		lastAcc = cyc;
		model(iw, pv, ph);
	endtask : issue
	// Lowering valid and draining both queues keeps the next issue off this time step.
	task automatic idle;
		int n;
		instrValid <= 1'b0;
		n = 0;
		do begin @(posedge clk); n++; end while (wq.size() + rq.size() > 0 && n < 50);
		if (n >= 50) begin fails++; report_and_stop(); end
		@(posedge clk);
		expGap = 0;
	endtask : idle
	always @(posedge clk) begin
		if (wrEn === 1'b1) begin
			rf[wrAddr] <= wrData;
			if (wq.size() == 0) check(1'b1, 1'b0);
			else check({wrAddr, wrData, statusCarryFlag}, wq.pop_front());
		end
		if (redirectValid === 1'b1) begin
			if (rq.size() == 0) check(1'b1, 1'b0);
			else check(redirectPc, rq.pop_front());
		end
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] q;
		logic e;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0, q, e);
			check({e, q}, 33'h0);
		end
		apb(1'b0, 8'h10, 32'h0, q, e);
		check({e, q}, {1'b1, 32'h0});
		apb(1'b1, abe_pkg::ADDR_PC, 32'h100, q, e);
		apb(1'b0, abe_pkg::ADDR_PC, 32'h0, q, e);
		check(q, 32'h100);
		apb(1'b1, abe_pkg::ADDR_CTRL, 32'h1, q, e);
		mpc = 32'h100;
	endtask : t_regs
	// Every add variant back to back, each reading the result of the one before.
	task automatic t_alu;
		logic [31:0] q;
		logic e;
		for (int k = 0; k < 8; k++) begin
			issue(mk({2'b00, k[2:0], 1'b0}, 5'(5 + k), 5'(4 + k),
				k[2] ? 16'hfff0 : {5'd2, 11'h0}));
		end
		issue(mk(abe_pkg::OPC_AND, 5'd13, 5'd12, {5'd3, 11'h0}));
		issue(mk(abe_pkg::OPC_ANDI, 5'd14, 5'd13, 16'h8f0f));
		issue(mk(abe_pkg::OPC_ANDN, 5'd15, 5'd14, {5'd3, 11'h0}));
		issue(mk(abe_pkg::OPC_ANDNI, 5'd16, 5'd15, 16'h80ff));
		issue(mk(abe_pkg::OPC_ADDI, 5'd17, 5'd16, 16'h1234), 1'b1, 16'habcd);
		idle();
		apb(1'b0, abe_pkg::ADDR_STATUS, 32'h0, q, e);
		check(q[0], mc);
		apb(1'b0, abe_pkg::ADDR_RETIRED, 32'h0, q, e);
		check(q, 32'h0000_000d);
	endtask : t_alu
	// Both branch forms, taken or not, with and without a slot, each followed by two ALU ops.
	task automatic t_branch;
		for (int k = 0; k < 8; k++) begin
			issue(mk(k[0] ? abe_pkg::OPC_BEQI : abe_pkg::OPC_BEQ, {k[1], 4'h0},
				k[2] ? 5'd2 : 5'd0, k[0] ? 16'hffc0 : {5'd20, 11'h0}));
			issue(mk(abe_pkg::OPC_ADD, 5'd24, 5'd24, {5'd2, 11'h0}));
			issue(mk(k[0] ? abe_pkg::OPC_ANDN : abe_pkg::OPC_AND, 5'd25, 5'd1, {5'd3, 11'h0}));
		end
		idle();
	endtask : t_branch
	// A register add with a stray tail bit is consumed: no write, pc steps, sticky flag set.
	task automatic t_refuse;
		logic [31:0] q;
		logic e;
		int n;
		instrValid <= 1'b1;
		instrWord <= mk(abe_pkg::OPC_ADD, 5'd26, 5'd1, 16'h0001);
		immPrefixValid <= 1'b0;
		n = 0;
		do begin @(posedge clk); n++; end while (instrReady !== 1'b1 && n < 50);
		if (n >= 50) begin fails++; report_and_stop(); end
		check(pcOut, mpc);
		mpc = mpc + 32'h4;
		idle();
		apb(1'b0, abe_pkg::ADDR_STATUS, 32'h0, q, e);
		check(q[abe_pkg::STAT_ILLEGAL_BIT], 1'b1);
		check(pcOut, mpc);
		check(statusCarryFlag, mc);
	endtask : t_refuse
	initial begin
		for (int i = 0; i < 32; i++) begin
			rf[i] = i * 32'h1357_9bdf;
		end
		rf[20] = 32'h40;
		mrf = rf;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_alu();
		t_branch();
		t_refuse();
		report_and_stop();
	end
endmodule : tb_abe_exec_top
bind abe_exec_top abe_exec_props abe_exec_props_inst (.clk(clk), .rst(rst),
	.instrValid(instrValid), .instrReady(instrReady), .instrWord(instrWord),
	.immPrefixValid(immPrefixValid), .immPrefixHigh(immPrefixHigh), .rdAddrA(rdAddrA),
	.rdAddrB(rdAddrB), .rdDataA(rdDataA), .rdDataB(rdDataB), .wrEn(wrEn), .wrAddr(wrAddr),
	.wrData(wrData), .pcOut(pcOut), .redirectValid(redirectValid), .redirectPc(redirectPc),
	.statusCarryFlag(statusCarryFlag));
